/* design/bss_seq.sv */
// Burner safety sequencer: supervises a running burner and its trips.
// Assumes an outside light-off sequencer drives the req inputs, reports
// firing and ignition failure, and restarts on lightoff_start_out.
// All inputs but rstn_in are synchronous to core_clk_in; switch inputs are 1 = closed.
`timescale 1ns/1ps
`include "bss_consts.svh"

module bss_seq #(
  parameter int TICK_CYCLES = `BSS_TICK_CYCLES,
  parameter int BLINK_CYCLES = `BSS_BLINK_CYCLES
) (
  input wire logic core_clk_in, // 40 MHz clock
  input wire logic rstn_in, // Async reset, low
  input wire logic heat_req_in, // Thermostat call for heat
  input wire logic fan_temp_ok_in, // Fan temperature switch closed
  input wire logic high_limit_ok_in, // Water high limit closed
  input wire logic flame_in, // Flame sensed
  input wire logic airflow_in, // Airflow switch closed
  input wire logic firing_in, // Light-off done, burner expected lit
  input wire logic trial_in, // Ignition trial under way
  input wire logic ign_fail_in, // Ignition trial failed, pulse
  input wire logic valve_req_in, // Light-off asks for gas valve
  input wire logic igniter_req_in, // Light-off asks for igniter
  input wire logic fan_req_in, // Light-off asks for fan
  output logic gas_valve_out, // Gas valve drive
  output logic igniter_out, // Igniter drive
  output logic fan_out, // Draft fan drive
  output logic pump_out, // Circulator drive
  output logic lightoff_start_out, // Restart light-off, pulse
  output logic valve_led_out, // Valve indicator
  output logic purge_led_out, // Purge indicator
  output bss_pkg::bss_flame_led_t flame_led_out, // Flame indicator level
  output logic lock_flame_out, // In flame lockout
  output logic lock_air_out // In airflow lockout
);
  import bss_pkg::*;

  bss_state_t state_reg;
  bss_state_t state_next;
  bss_cause_t cause_reg;
  bss_cause_t cause_next;
  logic [1:0] attempt_reg;
  logic [1:0] attempt_next;
  logic [`BSS_SEC_W-1:0] sec;
  logic blink;
  logic tmr_clr;
  logic trip;
  logic flame_lost;
  logic air_lost;
  logic valve_ok;
  logic gas_valve_reg;
  logic igniter_reg;
  logic fan_reg;
  logic pump_reg;
  logic start_reg;
  logic valve_led_reg;
  logic purge_led_reg;
  bss_flame_led_t flame_led_reg;
  logic lock_flame_reg;
  logic lock_air_reg;

  function automatic logic elapsed(input logic [`BSS_SEC_W-1:0] cnt,
                                   input logic [`BSS_SEC_W-1:0] lim);
    elapsed = (cnt >= lim);
  endfunction

  function automatic logic is_lock(input bss_state_t st);
    is_lock = (st == BSS_LOCKF) || (st == BSS_LOCKA);
  endfunction

  bss_timer #(
    .TICK_CYCLES(TICK_CYCLES),
    .BLINK_CYCLES(BLINK_CYCLES)
  ) bss_timer_inst (
    .core_clk_in(core_clk_in),
    .rstn_in(rstn_in),
    .clr_in(tmr_clr),
    .sec_out(sec),
    .blink_out(blink)
  );

  assign trip = !fan_temp_ok_in || !high_limit_ok_in;
  assign flame_lost = firing_in && !flame_in;
  assign air_lost = firing_in && !airflow_in;
  assign valve_ok = (state_reg == BSS_LIGHTOFF) && !trip && !flame_lost &&
                    !air_lost && !ign_fail_in && heat_req_in;
  assign tmr_clr = (state_next != state_reg);

  always_comb begin
    state_next = state_reg;
    cause_next = cause_reg;
    attempt_next = attempt_reg;
    unique case (state_reg)
      BSS_IDLE: begin
        attempt_next = `BSS_ATTEMPT_RST;
        if (heat_req_in && !trip) begin
          state_next = BSS_LIGHTOFF;
        end
      end
      BSS_LIGHTOFF: begin
        if (trip || !heat_req_in) begin
          state_next = BSS_PURGE;
          cause_next = BSS_CAUSE_TRIP;
        end else if (air_lost) begin
          state_next = BSS_PURGE;
          cause_next = BSS_CAUSE_AIR;
        end else if (flame_lost || ign_fail_in) begin
          state_next = BSS_PURGE;
          cause_next = BSS_CAUSE_FLAME;
        end else if (firing_in && flame_in) begin
          attempt_next = `BSS_ATTEMPT_RST;
        end
      end
      BSS_PURGE: begin
        if (elapsed(sec, `BSS_SEC_W'(`BSS_POSTPURGE_TICKS))) begin
          if (!heat_req_in) begin
            state_next = BSS_IDLE;
          end else if (cause_reg == BSS_CAUSE_AIR) begin
            state_next = BSS_AIRWAIT;
          end else if (cause_reg == BSS_CAUSE_FLAME) begin
            if (attempt_reg == `BSS_RELIGHT_MAX) begin
              state_next = BSS_LOCKF;
            end else if (!trip) begin
              attempt_next = attempt_reg + 2'h1;
              state_next = BSS_LIGHTOFF;
            end else begin
              state_next = BSS_TRIPWAIT;
            end
          end else begin
            state_next = BSS_TRIPWAIT;
          end
        end
      end
      BSS_AIRWAIT: begin
        if (!heat_req_in) begin
          state_next = BSS_IDLE;
        end else if (airflow_in && !trip) begin
          state_next = BSS_LIGHTOFF;
        end else if (elapsed(sec, `BSS_SEC_W'(`BSS_AIRWAIT_TICKS))) begin
          state_next = BSS_LOCKA;
        end
      end
      BSS_TRIPWAIT: begin
        if (!heat_req_in) begin
          state_next = BSS_IDLE;
        end else if (!trip) begin
          state_next = BSS_LIGHTOFF;
        end
      end
      BSS_LOCKF: begin
        if (!heat_req_in) begin
          state_next = BSS_IDLE;
        end else if (elapsed(sec, `BSS_SEC_W'(`BSS_LOCKFLAME_TICKS))) begin
          state_next = BSS_IDLE;
        end
      end
      BSS_LOCKA: begin
        if (!heat_req_in) begin
          state_next = BSS_IDLE;
        end else if (elapsed(sec, `BSS_SEC_W'(`BSS_LOCKAIR_TICKS))) begin
          state_next = BSS_IDLE;
        end
      end
      default: begin
        state_next = BSS_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_reg <= BSS_IDLE;
      cause_reg <= BSS_CAUSE_TRIP;
      attempt_reg <= `BSS_ATTEMPT_RST;
    end else begin
      state_reg <= state_next;
      cause_reg <= cause_next;
      attempt_reg <= attempt_next;
    end
  end

  // Burner drives; decided from live inputs so a trip acts next edge
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      gas_valve_reg <= 1'b0;
      igniter_reg <= 1'b0;
    end else begin
      gas_valve_reg <= valve_ok && valve_req_in;
      igniter_reg <= valve_ok && igniter_req_in;
    end
  end

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      fan_reg <= 1'b0;
    end else begin
      // fan kept on to prove air
      fan_reg <= (state_next == BSS_PURGE) || (state_next == BSS_AIRWAIT) ||
                 ((state_next == BSS_LIGHTOFF) && fan_req_in);
    end
  end

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pump_reg <= 1'b0;
    end else begin
      pump_reg <= heat_req_in;
    end
  end

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      start_reg <= 1'b0;
    end else begin
      start_reg <= (state_next == BSS_LIGHTOFF) && (state_reg != BSS_LIGHTOFF);
    end
  end

  // Indicators
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      valve_led_reg <= 1'b0;
      purge_led_reg <= 1'b0;
    end else begin
      valve_led_reg <= (state_next == BSS_LOCKF) ? blink :
                       (valve_ok && valve_req_in);
      purge_led_reg <= (state_next == BSS_LOCKA) ? blink :
                       (fan_req_in && airflow_in && (state_next == BSS_LIGHTOFF) &&
                        !firing_in) ||
                       (((state_next == BSS_PURGE) || (state_next == BSS_AIRWAIT)) &&
                        airflow_in);
    end
  end

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      flame_led_reg <= BSS_LED_OFF;
    end else if (!valve_ok) begin
      flame_led_reg <= BSS_LED_OFF;
    end else if (firing_in && flame_in) begin
      flame_led_reg <= BSS_LED_BRIGHT;
    end else if (trial_in) begin
      flame_led_reg <= BSS_LED_DIM;
    end else begin
      flame_led_reg <= BSS_LED_OFF;
    end
  end

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      lock_flame_reg <= 1'b0;
      lock_air_reg <= 1'b0;
    end else begin
      lock_flame_reg <= is_lock(state_next) && (state_next == BSS_LOCKF);
      lock_air_reg <= is_lock(state_next) && (state_next == BSS_LOCKA);
    end
  end

  assign gas_valve_out = gas_valve_reg;
  assign igniter_out = igniter_reg;
  assign fan_out = fan_reg;
  assign pump_out = pump_reg;
  assign lightoff_start_out = start_reg;
  assign valve_led_out = valve_led_reg;
  assign purge_led_out = purge_led_reg;
  assign flame_led_out = flame_led_reg;
  assign lock_flame_out = lock_flame_reg;
  assign lock_air_out = lock_air_reg;

endmodule

/* design/bss_consts.svh */
// Constants of the burner safety sequencer: times, limits, reset values.
// Assumes it is included by its bare name from the design files only.
`ifndef BSS_CONSTS_SVH
`define BSS_CONSTS_SVH

`define BSS_CLK_HZ 40000000
`define BSS_TICK_S 1
`define BSS_TICK_CYCLES (`BSS_CLK_HZ * `BSS_TICK_S)
`define BSS_BLINK_MS 500
`define BSS_BLINK_CYCLES (`BSS_CLK_HZ / 1000 * `BSS_BLINK_MS)

`define BSS_POSTPURGE_S 30
`define BSS_AIRWAIT_MIN 5
`define BSS_LOCKAIR_MIN 15
`define BSS_LOCKFLAME_H 1
`define BSS_POSTPURGE_TICKS (`BSS_POSTPURGE_S / `BSS_TICK_S)
`define BSS_AIRWAIT_TICKS (`BSS_AIRWAIT_MIN * 60 / `BSS_TICK_S)
`define BSS_LOCKAIR_TICKS (`BSS_LOCKAIR_MIN * 60 / `BSS_TICK_S)
`define BSS_LOCKFLAME_TICKS (`BSS_LOCKFLAME_H * 3600 / `BSS_TICK_S)

`define BSS_SEC_W 12
`define BSS_PRE_W 26
`define BSS_RELIGHT_MAX 2'h3
`define BSS_ATTEMPT_RST 2'h0
`define BSS_SEC_RST 12'h000
`define BSS_PRE_RST 26'h0000000

`endif

/* design/bss_pkg.sv */
// Types shared by the burner safety sequencer files.
// Assumes bss_consts.svh is available on the include path.
package bss_pkg;

  typedef enum logic [2:0] {
    BSS_IDLE     = 3'h0,
    BSS_LIGHTOFF = 3'h1,
    BSS_PURGE    = 3'h2,
    BSS_AIRWAIT  = 3'h3,
    BSS_TRIPWAIT = 3'h4,
    BSS_LOCKF    = 3'h5,
    BSS_LOCKA    = 3'h6
  } bss_state_t;

  typedef enum logic [1:0] {
    BSS_CAUSE_TRIP  = 2'h0,
    BSS_CAUSE_FLAME = 2'h1,
    BSS_CAUSE_AIR   = 2'h2
  } bss_cause_t;

  typedef enum logic [1:0] {
    BSS_LED_OFF    = 2'h0,
    BSS_LED_DIM    = 2'h1,
    BSS_LED_BRIGHT = 2'h2
  } bss_flame_led_t;

endpackage

/* design/bss_timer.sv */
// Seconds counter and blink phase for the burner safety sequencer.
// Assumes clr_in is raised for one cycle whenever a timed state is entered.
`timescale 1ns/1ps
`include "bss_consts.svh"

module bss_timer #(
  parameter int TICK_CYCLES = `BSS_TICK_CYCLES,
  parameter int BLINK_CYCLES = `BSS_BLINK_CYCLES
) (
  input wire logic core_clk_in, // 40 MHz clock
  input wire logic rstn_in, // Async reset, low
  input wire logic clr_in, // Restart count
  output logic [`BSS_SEC_W-1:0] sec_out, // Seconds since clear
  output logic blink_out // Blink phase
);

  logic [`BSS_PRE_W-1:0] pre_reg;
  logic [`BSS_SEC_W-1:0] sec_reg;
  logic [`BSS_PRE_W-1:0] blk_reg;
  logic blink_reg;

  // Interval timing from internal clock
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pre_reg <= `BSS_PRE_RST;
      sec_reg <= `BSS_SEC_RST;
    end else if (clr_in) begin
      pre_reg <= `BSS_PRE_RST;
      sec_reg <= `BSS_SEC_RST;
    end else if (pre_reg == `BSS_PRE_W'(TICK_CYCLES - 1)) begin
      pre_reg <= `BSS_PRE_RST;
      // Saturates so long waits cannot wrap back to zero
      if (sec_reg != {`BSS_SEC_W{1'b1}}) begin
        sec_reg <= sec_reg + `BSS_SEC_W'(1);
      end
    end else begin
      pre_reg <= pre_reg + `BSS_PRE_W'(1);
    end
  end

  // Free running, so every lockout blinks at the same rate
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      blk_reg <= `BSS_PRE_RST;
      blink_reg <= 1'b0;
    end else if (blk_reg == `BSS_PRE_W'(BLINK_CYCLES - 1)) begin
      blk_reg <= `BSS_PRE_RST;
      blink_reg <= ~blink_reg;
    end else begin
      blk_reg <= blk_reg + `BSS_PRE_W'(1);
    end
  end

  assign sec_out = sec_reg;
  assign blink_out = blink_reg;

endmodule

/* tb/bss_far_side.sv */
// Far-side model: flame follows the gas valve, airflow follows the fan.
// Assumes the bench raises the fault inputs to fake a dead flame or a blocked vent.
`timescale 1ns/1ps
module bss_far_side (
  input wire logic core_clk_in, // Clock
  input wire logic rstn_in, // Reset, low
  input wire logic valve_in, // Gas valve drive
  input wire logic fan_in, // Fan drive
  input wire logic no_flame_in, // Kill flame
  input wire logic block_air_in, // Block vent
  output logic flame_out, // Flame sensed
  output logic airflow_out // Airflow switch
);
  // One cycle lag: a real sensor never answers on the same edge
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      flame_out <= 1'h0;
      airflow_out <= 1'h0;
    end else begin
      flame_out <= valve_in && !no_flame_in;
      airflow_out <= fan_in && !block_air_in;
    end
  end
endmodule

/* tb/bss_seq_sva.sv */
// Port assertions for the burner safety sequencer.
// Assumes the bind hands on the shortened tick parameter.
`timescale 1ns/1ps
module bss_seq_sva #(
  parameter int TICK_CYCLES = 4
) (
  input wire logic core_clk_in, // Clock
  input wire logic rstn_in, // Reset
  input wire logic heat_req_in, // Heat
  input wire logic fan_temp_ok_in, // Fan temp
  input wire logic high_limit_ok_in, // Limit
  input wire logic flame_in, // Flame
  input wire logic airflow_in, // Air
  input wire logic firing_in, // Firing
  input wire logic gas_valve_out, // Valve
  input wire logic igniter_out, // Igniter
  input wire logic fan_out, // Fan
  input wire logic pump_out, // Pump
  input wire logic valve_led_out, // Valve led
  input wire logic purge_led_out, // Purge led
  input bss_pkg::bss_flame_led_t flame_led_out, // Flame led
  input wire logic lock_flame_out, // Flame lock
  input wire logic lock_air_out // Air lock
);
  import bss_pkg::*;
  localparam int FL_MAX = 3600 * TICK_CYCLES + 4;
  localparam int AL_MAX = 900 * TICK_CYCLES + 4;
  int fl_cnt;
  int al_cnt;
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rstn_in);
  // Time spent in each lockout
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      fl_cnt <= 0;
      al_cnt <= 0;
    end else begin
      fl_cnt <= lock_flame_out ? fl_cnt + 1 : 0;
      al_cnt <= lock_air_out ? al_cnt + 1 : 0;
    end
  end
  sequence s_trip_firing;
    gas_valve_out && !fan_temp_ok_in;
  endsequence
  sequence s_limit_firing;
    gas_valve_out && !high_limit_ok_in;
  endsequence
  sequence s_post_purge;
    fan_out [*8] ##[100:125] !fan_out;
  endsequence
  a_trip_drops_valve: assert property (
    !fan_temp_ok_in |=> !gas_valve_out && (lock_flame_out || !valve_led_out))
    else $error("valve open after fan temperature trip");
  a_trip_post_purge: assert property (s_trip_firing |=> s_post_purge)
    else $error("fan post purge wrong after trip");
  a_flame_loss_off: assert property (
    firing_in && gas_valve_out && !flame_in
    |=> !gas_valve_out && !valve_led_out && flame_led_out == BSS_LED_OFF)
    else $error("valve or lights on after flame loss");
  a_air_loss_purge: assert property (
    gas_valve_out && !airflow_in |=> !gas_valve_out && fan_out)
    else $error("no purge after airflow loss");
  a_limit_drops_valve: assert property (
    $fell(high_limit_ok_in) |=> !gas_valve_out && flame_led_out == BSS_LED_OFF &&
    (lock_flame_out || !valve_led_out))
    else $error("valve or flame light on after limit trip");
  a_limit_post_purge: assert property (s_limit_firing |=> s_post_purge)
    else $error("fan post purge wrong after limit trip");
  a_flame_led_off: assert property (
    firing_in && !flame_in |=> flame_led_out != BSS_LED_BRIGHT)
    else $error("flame light bright without flame");
  a_purge_led_steady: assert property (
    purge_led_out && !lock_air_out |-> fan_out && $past(airflow_in))
    else $error("purge light on without fan and airflow");
  a_pump_follows_heat: assert property (heat_req_in |=> pump_out)
    else $error("pump off during heat request");
  a_lock_holds_off: assert property (
    lock_flame_out || lock_air_out |-> !gas_valve_out && !igniter_out)
    else $error("valve or igniter on in lockout");
  a_flame_lock_blink: assert property (
    $rose(lock_flame_out) |-> ##[0:5] valve_led_out ##[1:5] !valve_led_out)
    else $error("valve light not blinking in flame lockout");
  a_air_lock_blink: assert property (
    $rose(lock_air_out) |-> ##[0:5] purge_led_out ##[1:5] !purge_led_out)
    else $error("purge light not blinking in airflow lockout");
  a_flame_lock_span: assert property (fl_cnt <= FL_MAX)
    else $error("flame lockout outlasted its limit");
  a_air_lock_span: assert property (al_cnt <= AL_MAX)
    else $error("airflow lockout outlasted its limit");
endmodule

bind bss_seq bss_seq_sva #(.TICK_CYCLES(TICK_CYCLES)) bss_seq_sva_inst (
  .core_clk_in, .rstn_in, .heat_req_in, .fan_temp_ok_in, .high_limit_ok_in, .flame_in,
  .airflow_in, .firing_in, .gas_valve_out, .igniter_out, .fan_out, .pump_out,
  .valve_led_out, .purge_led_out, .flame_led_out, .lock_flame_out, .lock_air_out);

/* tb/test_bss_seq.sv */
// Bench for the burner safety sequencer with the far-side model in the loop.
// Assumes a short tick so hour-long lockouts fit the run.
`timescale 1ns/1ps
module test_bss_seq;
  import bss_pkg::*;
  localparam int TICK = 4;
  localparam int PURGE = 30 * TICK;
  typedef struct {logic [3:0] fault; logic relight; logic fan_after;} bss_row_t;
  logic core_clk_in, rstn_in, heat_req_in, fan_temp_ok_in, high_limit_ok_in, flame_in;
  logic airflow_in, firing_in, trial_in, ign_fail_in, valve_req_in, igniter_req_in;
  logic fan_req_in, gas_valve_out, igniter_out, fan_out, pump_out, lightoff_start_out;
  logic valve_led_out, purge_led_out, lock_flame_out, lock_air_out, no_flame, block_air;
  logic seen;
  bss_flame_led_t flame_led_out;
  int mismatches, compares, n;
  // Fault bits: fan temp, high limit, flame, airflow
  bss_row_t rows [4] = '{'{4'h1, 1'h0, 1'h0}, '{4'h2, 1'h0, 1'h0},
                         '{4'h4, 1'h1, 1'h0}, '{4'h8, 1'h0, 1'h1}};

  bss_seq #(.TICK_CYCLES(TICK), .BLINK_CYCLES(2)) bss_seq_inst (
    .core_clk_in, .rstn_in, .heat_req_in, .fan_temp_ok_in, .high_limit_ok_in, .flame_in,
    .airflow_in, .firing_in, .trial_in, .ign_fail_in, .valve_req_in, .igniter_req_in,
    .fan_req_in, .gas_valve_out, .igniter_out, .fan_out, .pump_out, .lightoff_start_out,
    .valve_led_out, .purge_led_out, .flame_led_out, .lock_flame_out, .lock_air_out);
  bss_far_side bss_far_side_inst (.core_clk_in, .rstn_in, .valve_in(gas_valve_out),
    .fan_in(fan_out), .no_flame_in(no_flame), .block_air_in(block_air),
    .flame_out(flame_in), .airflow_out(airflow_in));

  initial begin
    core_clk_in = 1'h0;
    forever #12.5 core_clk_in = ~core_clk_in;
  end

  task automatic tally_and_finish();
    if (mismatches == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk_bit(input string nm, input logic e, input logic g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_led(input bss_flame_led_t e);
    compares++;
    if (flame_led_out !== e) begin
      mismatches++;
      $display("BAD flame_led expected %h seen %h", e, flame_led_out);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge core_clk_in);
  endtask
  task automatic clr_req();
    {firing_in, trial_in, valve_req_in, igniter_req_in, fan_req_in} = 5'h00;
  endtask
  task automatic do_reset();
    rstn_in = 1'h0;
    {heat_req_in, fan_temp_ok_in, high_limit_ok_in, ign_fail_in} = 4'he;
    {no_flame, block_air} = 2'h0;
    clr_req();
    cyc(2);
    chk_bit("lock_rst", 1'h0, lock_air_out | lock_flame_out);
    rstn_in = 1'h1;
    cyc(1);
    chk_bit("start", 1'h1, lightoff_start_out);
  endtask
  // Plays the light-off sequencer up to a proven flame
  task automatic light();
    {fan_req_in, igniter_req_in, trial_in} = 3'h7;
    cyc(4);
    chk_bit("purge_led", 1'h1, purge_led_out);
    chk_led(BSS_LED_DIM);
    chk_bit("igniter_on", 1'h1, igniter_out);
    valve_req_in = 1'h1;
    cyc(3);
    {firing_in, trial_in, igniter_req_in} = 3'h4;
    cyc(2);
    chk_bit("valve_on", 1'h1, gas_valve_out);
    chk_led(BSS_LED_BRIGHT);
    chk_bit("igniter_off", 1'h0, igniter_out);
  endtask
  task automatic wait_sig(input logic which, input int lim);
    n = 0;
    while ((which ? lock_air_out : (lightoff_start_out | lock_flame_out)) !== 1'h1
           && n < lim) begin
      cyc(1);
      n++;
    end
  endtask
  task automatic to_lock_air();
    do_reset();
    light();
    block_air = 1'h1;
    cyc(3);
    clr_req();
    wait_sig(1'h1, 1500);
    chk_bit("lock_a", 1'h1, lock_air_out);
    chk_bit("air_wait", 1'h1, n > 1300);
  endtask
  task automatic span(input string nm, input int lim);
    n = 0;
    while ((lock_flame_out | lock_air_out) === 1'h1 && n < lim + 50) begin
      cyc(1);
      n++;
    end
    chk_bit(nm, 1'h1, n > lim - 8 && n < lim + 4);
  endtask

  initial begin
    mismatches = 0;
    compares = 0;
    for (int i = 0; i < 4; i++) begin
      do_reset();
      light();
      {block_air, no_flame} = rows[i].fault[3:2];
      {high_limit_ok_in, fan_temp_ok_in} = ~rows[i].fault[1:0];
      cyc(3);
      chk_bit("valve_off", 1'h0, gas_valve_out);
      chk_bit("valve_led", 1'h0, valve_led_out);
      chk_led(BSS_LED_OFF);
      chk_bit("fan", 1'h1, fan_out);
      clr_req();
      cyc(PURGE - 12);
      chk_bit("fan_purge", 1'h1, fan_out);
      seen = 1'h0;
      repeat (20) begin
        cyc(1);
        seen |= lightoff_start_out;
      end
      chk_bit("relight", rows[i].relight, seen);
      chk_bit("fan_end", rows[i].fan_after, fan_out);
      chk_bit("pump", 1'h1, pump_out);
      {no_flame, block_air, high_limit_ok_in, fan_temp_ok_in} = 4'h3;
      seen = 1'h0;
      repeat (5) begin
        cyc(1);
        seen |= lightoff_start_out;
      end
      chk_bit("restart", !rows[i].relight, seen);
    end
    do_reset();
    light();
    no_flame = 1'h1;
    cyc(3);
    clr_req();
    for (int k = 0; k < 4; k++) begin
      wait_sig(1'h0, 200);
      chk_bit("relight_n", k < 3, lightoff_start_out);
      if (k < 3) begin
        ign_fail_in = 1'h1;
        cyc(1);
        ign_fail_in = 1'h0;
      end
    end
    chk_bit("lock_f", 1'h1, lock_flame_out);
    chk_bit("pump_lock", 1'h1, pump_out);
    span("lock_f_span", 3600 * TICK);
    to_lock_air();
    to_lock_air();
    heat_req_in = 1'h0;
    cyc(2);
    chk_bit("lock_heat", 1'h0, lock_air_out);
    chk_bit("pump_off", 1'h0, pump_out);
    heat_req_in = 1'h1;
    cyc(1);
    chk_bit("heat_start", 1'h1, lightoff_start_out);
    to_lock_air();
    span("lock_a_span", 900 * TICK);
    tally_and_finish();
  end

  // Run needs about 0.6 ms
  initial begin
    #1000000;
    mismatches++;
    tally_and_finish();
  end
endmodule
